//--- hdl/osr_pkg.sv
// Constants, types and field layout shared by both ends of the status link
// What this block does
// - Security read opcode, eight clocks, MSB first
// - Three address bytes; only bits 8:0 used
// - Bits 8:7 pick register, 6:0 the byte
// - One dummy byte precedes security data, discarded
// - Security bytes out MSB first, eight clocks each
// - Output runs on across all four registers
// - Host ends the read by raising select
// - Security and indirect reads: in on SI, out SO
// - Three direct opcodes pick status one to three
// - Direct read: opcode then data, no address
// - Direct read repeats the same byte endlessly
// - Each repeat samples live register contents
// - Select release mid-byte ends read, output floats
// - Indirect read: 8-bit address, 01h-06h map registers
// - Indirect: opcode, address byte, dummy byte, data
// - Indirect address increments after every output byte
// - First indirect data bit 7 at clock 24
// - Addresses 7 to 255 give undefined data
// - Address wraps from FFh to 00h
`default_nettype none

package osr_pkg;
  // Opcodes
  localparam logic [7:0] OSR_OP_OTP_RD = 8'h4B;
  localparam logic [7:0] OSR_OP_STAT1 = 8'h05;
  localparam logic [7:0] OSR_OP_STAT2 = 8'h35;
  localparam logic [7:0] OSR_OP_STAT3 = 8'h15;
  localparam logic [7:0] OSR_OP_STAT_IND = 8'h65;
  // Address layout
  localparam int OSR_OTP_AW = 9;
  localparam logic [1:0] OSR_OTP_ABYTES = 2'h3;
  localparam logic [1:0] OSR_IND_ABYTES = 2'h1;
  localparam int OSR_OTP_SEL_MSB = 8;
  localparam int OSR_OTP_SEL_LSB = 7;
  localparam int OSR_NUM_STAT = 6;
  // Status register indices on the link
  localparam logic [7:0] OSR_STAT_ONE_OFS = 8'h01;
  localparam logic [7:0] OSR_STAT_TWO_OFS = 8'h02;
  localparam logic [7:0] OSR_STAT_THREE_OFS = 8'h03;
  localparam logic [7:0] OSR_STAT_SIX_OFS = 8'h06;
  // Host register map, byte offsets
  localparam logic [7:0] OSR_CTRL_OFS = 8'h00;
  localparam logic [7:0] OSR_ADDR_OFS = 8'h04;
  localparam logic [7:0] OSR_STATUS_OFS = 8'h08;
  localparam logic [7:0] OSR_RXDATA_OFS = 8'h0C;
  // Host control fields
  localparam int OSR_CTRL_ABYTES_LSB = 8;
  localparam int OSR_CTRL_DUMMY_BIT = 10;
  localparam int OSR_CTRL_NBYTES_LSB = 16;
  localparam int OSR_CTRL_GO_BIT = 31;
  localparam int OSR_STATUS_BUSY_BIT = 0;
  localparam int OSR_STATUS_RXV_BIT = 1;
  localparam logic [31:0] OSR_CTRL_RST = 32'h0000_0000;
  localparam logic [23:0] OSR_ADDR_RST = 24'h00_0000;
  // Host clock cycles per half period of the serial clock
  localparam int OSR_SCK_HALF_CYC = 12;

  typedef enum logic [2:0] {
    OSR_D_IDLE, OSR_D_CMD, OSR_D_ADDR, OSR_D_DUMMY, OSR_D_DATA, OSR_D_IGNORE
  } osr_dev_state_e;
  typedef enum logic [1:0] {OSR_M_OTP, OSR_M_DIR, OSR_M_IND} osr_mode_e;
  typedef enum logic [2:0] {
    OSR_H_IDLE, OSR_H_LEAD, OSR_H_SHIFT, OSR_H_TRAIL, OSR_H_GAP
  } osr_host_state_e;
endpackage

`default_nettype wire

//--- hdl/osr_link.sv
// Serial link between host controller and status device
`default_nettype none

interface osr_link;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  modport dev (input cs_n, input sck, input si, output so, output so_oe);
  modport host (output cs_n, output sck, output si, input so, input so_oe);
endinterface

`default_nettype wire

//--- hdl/osr_sync.sv
// Three-flop input synchroniser with agreement filter
`default_nettype none

module osr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk, // Sampling clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Filtered, synchronous levels
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Stage one is read only by stage two
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Change counts only when stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= RST;
    else
      q <= (s2_q & ~(s2_q ^ s3_q)) | (q & (s2_q ^ s3_q));
  end
endmodule

`default_nettype wire

//--- hdl/osr_device.sv
// Device end: security and status read command logic
//
// Implementation choice: status and security bytes come in on ports; AHB-Lite is at the host end.
`default_nettype none

module osr_device (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  osr_link.dev link, // Serial link, device side
  input wire logic [47:0] status_bytes, // Live status 1..6, one at [7:0]
  output logic [osr_pkg::OSR_OTP_AW-1:0] otp_addr, // Security byte index
  input wire logic [7:0] otp_rdata, // Byte at otp_addr
  output logic busy // Select seen asserted
);
  import osr_pkg::*;

  logic [2:0] pins_f;
  logic cs_n_f;
  logic sck_f;
  logic si_f;
  logic sck_prev_q;
  logic cs_prev_q;
  logic cs_start;
  logic sck_rise;
  logic sck_fall;
  osr_dev_state_e state_q;
  osr_mode_e mode_q;
  logic [2:0] bit_q;
  logic [6:0] shift_q;
  logic [7:0] byte_in;
  logic byte_done;
  logic [1:0] abytes_q;
  logic [OSR_OTP_AW-1:0] addr_q;
  logic [7:0] dir_reg_q;
  logic load_pend_q;
  logic [7:0] out_q;
  logic [7:0] fetch;
  logic so_q;
  logic so_oe_q;
  logic busy_q;

  // Pick status byte by link index; anything outside 1..6 reads zero
  function automatic logic [7:0] stat_byte(input logic [47:0] s,
                                           input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 1; i <= OSR_NUM_STAT; i++)
    begin
      if (a == 8'(i))
        r = s[8*(i-1) +: 8];
    end
    return r;
  endfunction

  // Link pins come from another party, so they pass the filter
  // Filter resets to the idle levels of the pins so no false edge follows
  osr_sync #(.W(3), .RST(3'b100)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({link.cs_n, link.sck, link.si}),
    .q(pins_f)
  );
  assign cs_n_f = pins_f[2];
  assign sck_f = pins_f[1];
  assign si_f = pins_f[0];

  // Edge detection on filtered levels
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end
    else
    begin
      sck_prev_q <= sck_f;
      cs_prev_q <= cs_n_f;
    end
  end
  assign cs_start = cs_prev_q & ~cs_n_f;
  assign sck_rise = sck_f & ~sck_prev_q & ~cs_n_f;
  assign sck_fall = ~sck_f & sck_prev_q & ~cs_n_f;
  assign byte_in = {shift_q, si_f};
  assign byte_done = sck_rise && (bit_q == 3'h7);

  // Input shifter and bit counter, MSB arrives first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bit_q <= 3'h0;
      shift_q <= 7'h00;
    end
    else if (cs_start)
    begin
      bit_q <= 3'h0;
      shift_q <= 7'h00;
    end
    else if (sck_rise)
    begin
      bit_q <= bit_q + 3'h1;
      shift_q <= byte_in[6:0];
    end
  end

  // Command sequencer, one step per completed byte
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= OSR_D_IDLE;
      mode_q <= OSR_M_OTP;
      abytes_q <= 2'h0;
      dir_reg_q <= 8'h00;
    end
    else if (cs_n_f)
      state_q <= OSR_D_IDLE;
    else if (cs_start)
      state_q <= OSR_D_CMD;
    else if (byte_done)
    begin
      unique case (state_q)
        OSR_D_CMD:
        begin
          unique case (byte_in)
            OSR_OP_OTP_RD:
            begin
              mode_q <= OSR_M_OTP;
              abytes_q <= OSR_OTP_ABYTES - 2'h1;
              state_q <= OSR_D_ADDR;
            end
            OSR_OP_STAT_IND:
            begin
              mode_q <= OSR_M_IND;
              abytes_q <= OSR_IND_ABYTES - 2'h1;
              state_q <= OSR_D_ADDR;
            end
            OSR_OP_STAT1, OSR_OP_STAT2, OSR_OP_STAT3:
            begin
              mode_q <= OSR_M_DIR;
              state_q <= OSR_D_DATA;
              if (byte_in == OSR_OP_STAT1)
                dir_reg_q <= OSR_STAT_ONE_OFS;
              else if (byte_in == OSR_OP_STAT2)
                dir_reg_q <= OSR_STAT_TWO_OFS;
              else
                dir_reg_q <= OSR_STAT_THREE_OFS;
            end
            default:
              state_q <= OSR_D_IGNORE;
          endcase
        end
        OSR_D_ADDR:
        begin
          if (abytes_q == 2'h0)
            state_q <= OSR_D_DUMMY;
          else
            abytes_q <= abytes_q - 2'h1;
        end
        OSR_D_DUMMY:
          state_q <= OSR_D_DATA;
        OSR_D_DATA, OSR_D_IGNORE, OSR_D_IDLE:
          state_q <= state_q;
        default:
          state_q <= OSR_D_IDLE;
      endcase
    end
  end

  // Start address capture and per-byte advance
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      addr_q <= '0;
    else if (byte_done && state_q == OSR_D_ADDR)
      addr_q <= {addr_q[0], byte_in};
    else if (byte_done && state_q == OSR_D_DATA)
    begin
      if (mode_q == OSR_M_OTP)
        addr_q <= addr_q + 9'h001;
      else if (mode_q == OSR_M_IND)
        addr_q <= {1'b0, addr_q[7:0] + 8'h01};
    end
  end
  // Bits 8:7 pick register and 6:0 the byte: a flat index
  assign otp_addr = addr_q;

  // Byte to send next, read at the moment it is loaded
  always_comb
  begin
    unique case (mode_q)
      OSR_M_OTP: fetch = otp_rdata;
      OSR_M_DIR: fetch = stat_byte(status_bytes, dir_reg_q);
      OSR_M_IND: fetch = stat_byte(status_bytes, addr_q[7:0]);
      default: fetch = 8'h00;
    endcase
  end

  // Load request after dummy, direct opcode or each data byte
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      load_pend_q <= 1'b0;
    else if (cs_n_f)
      load_pend_q <= 1'b0;
    else if (byte_done && (state_q == OSR_D_DUMMY || state_q == OSR_D_DATA))
      load_pend_q <= 1'b1;
    else if (byte_done && state_q == OSR_D_CMD && (byte_in == OSR_OP_STAT1
             || byte_in == OSR_OP_STAT2 || byte_in == OSR_OP_STAT3))
      load_pend_q <= 1'b1;
    else if (sck_fall)
      load_pend_q <= 1'b0;
  end

  // Output shifter changes on falling edges so rise sees it stable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_q <= 8'h00;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end
    else if (cs_n_f)
    begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end
    else if (sck_fall && load_pend_q)
    begin
      so_q <= fetch[7];
      out_q <= {fetch[6:0], 1'b0};
      so_oe_q <= 1'b1;
    end
    else if (sck_fall && so_oe_q)
    begin
      so_q <= out_q[7];
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  // Select activity indicator
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      busy_q <= 1'b0;
    else
      busy_q <= ~cs_n_f;
  end

  assign link.so = so_q;
  assign link.so_oe = so_oe_q;
  assign busy = busy_q;
endmodule

`default_nettype wire

//--- hdl/osr_host.sv
// Host end: AHB-Lite programmed serial read controller
`default_nettype none

module osr_host #(
  parameter int HALF_CYC = osr_pkg::OSR_SCK_HALF_CYC
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Always ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Always OKAY
  osr_link.host link // Serial link, host side
);
  import osr_pkg::*;

  logic so_f;
  osr_host_state_e state_q;
  logic [31:0] ctrl_q;
  logic [23:0] addr_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic addr_ok;
  logic start;
  logic [7:0] div_q;
  logic tick;
  logic [47:0] tx_q;
  logic [5:0] out_left_q;
  logic [9:0] nbytes_q;
  logic [2:0] dbit_q;
  logic [6:0] rx_sh_q;
  logic [7:0] rx_data_q;
  logic rx_valid_q;
  logic rx_set;
  logic rx_clr;
  logic sck_q;
  logic cs_n_q;
  logic si_q;
  logic stall;

  osr_sync #(.W(1), .RST(1'b0)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d(link.so),
    .q(so_f)
  );

  assign addr_ok = hsel && hready && htrans[1];
  assign start = wr_pend_q && wr_addr_q == OSR_CTRL_OFS
                 && hwdata[OSR_CTRL_GO_BIT] && state_q == OSR_H_IDLE;
  assign rx_clr = addr_ok && !hwrite && haddr[7:0] == OSR_RXDATA_OFS;

  // Bus phase tracking; zero wait states, read data from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[7:0];
      if (addr_ok && !hwrite)
      begin
        unique case (haddr[7:0])
          OSR_CTRL_OFS: hrdata_q <= ctrl_q;
          OSR_ADDR_OFS: hrdata_q <= {8'h00, addr_q};
          OSR_STATUS_OFS: hrdata_q <= {30'h0, rx_valid_q,
                                       state_q != OSR_H_IDLE};
          OSR_RXDATA_OFS: hrdata_q <= {24'h00_0000, rx_data_q};
          default: hrdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Setup registers; writes during a transfer are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= OSR_CTRL_RST;
      addr_q <= OSR_ADDR_RST;
    end
    else if (wr_pend_q && state_q == OSR_H_IDLE)
    begin
      if (wr_addr_q == OSR_CTRL_OFS)
        ctrl_q <= {1'b0, hwdata[30:0]};
      else if (wr_addr_q == OSR_ADDR_OFS)
        addr_q <= hwdata[23:0];
    end
  end

  // Half-period divider for the serial clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_q <= 8'h00;
    else if (state_q == OSR_H_IDLE || tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end
  assign tick = div_q == 8'(HALF_CYC - 1);
  // Unread byte holds off the next data byte instead of losing it
  assign stall = out_left_q == 6'h0 && dbit_q == 3'h0 && rx_valid_q;

  // Transfer sequencer, serial mode 0
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= OSR_H_IDLE;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      si_q <= 1'b0;
      tx_q <= 48'h0;
      out_left_q <= 6'h0;
      nbytes_q <= 10'h0;
      dbit_q <= 3'h0;
      rx_sh_q <= 7'h00;
      rx_data_q <= 8'h00;
      rx_set <= 1'b0;
    end
    else
    begin
      rx_set <= 1'b0;
      unique case (state_q)
        OSR_H_IDLE:
          if (start)
          begin
            cs_n_q <= 1'b0;
            unique case (hwdata[OSR_CTRL_ABYTES_LSB +: 2])
              2'h0: tx_q <= {hwdata[7:0], 40'h0};
              2'h1: tx_q <= {hwdata[7:0], addr_q[7:0], 32'h0};
              2'h2: tx_q <= {hwdata[7:0], addr_q[15:0], 24'h0};
              2'h3: tx_q <= {hwdata[7:0], addr_q, 16'h0};
            endcase
            si_q <= hwdata[7];
            out_left_q <= 6'h8 + {1'b0, hwdata[9:8], 3'h0}
                          + (hwdata[OSR_CTRL_DUMMY_BIT] ? 6'h8 : 6'h0);
            nbytes_q <= hwdata[OSR_CTRL_NBYTES_LSB +: 10];
            dbit_q <= 3'h0;
            state_q <= OSR_H_LEAD;
          end
        OSR_H_LEAD:
          if (tick)
            state_q <= OSR_H_SHIFT;
        OSR_H_SHIFT:
          if (tick && !sck_q && !stall)
            sck_q <= 1'b1;
          else if (tick && sck_q)
          begin
            sck_q <= 1'b0;
            if (out_left_q != 6'h0)
            begin
              tx_q <= {tx_q[46:0], 1'b0};
              si_q <= tx_q[46];
              out_left_q <= out_left_q - 6'h1;
              if (out_left_q == 6'h1 && nbytes_q == 10'h0)
                state_q <= OSR_H_TRAIL;
            end
            else
            begin
              rx_sh_q <= {rx_sh_q[5:0], so_f};
              dbit_q <= dbit_q + 3'h1;
              if (dbit_q == 3'h7)
              begin
                rx_data_q <= {rx_sh_q, so_f};
                rx_set <= 1'b1;
                nbytes_q <= nbytes_q - 10'h1;
                if (nbytes_q == 10'h1)
                  state_q <= OSR_H_TRAIL;
              end
            end
          end
        OSR_H_TRAIL:
          if (tick)
          begin
            cs_n_q <= 1'b1;
            state_q <= OSR_H_GAP;
          end
        OSR_H_GAP:
          if (tick)
            state_q <= OSR_H_IDLE;
        default:
          state_q <= OSR_H_IDLE;
      endcase
    end
  end

  // Received byte flag; a new byte wins over a clearing read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rx_valid_q <= 1'b0;
    else if (rx_set)
      rx_valid_q <= 1'b1;
    else if (rx_clr)
      rx_valid_q <= 1'b0;
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign link.cs_n = cs_n_q;
  assign link.sck = sck_q;
  assign link.si = si_q;
endmodule

`default_nettype wire

//--- test/osr_link_sva.sv
// Wire-level checks on the serial link between host and device
`default_nettype none

module osr_link_sva (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic cs_n, // Chip select, active low
  input wire logic sck, // Serial clock
  input wire logic si, // Host to device data
  input wire logic so, // Device to host data
  input wire logic so_oe // Device output enable
);
  logic sck_q;
  logic [5:0] rise_q;
  logic [7:0] op_q;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Previous sck level, for edge detection on the raw wire
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sck_q <= 1'b0;
    else
      sck_q <= sck;
  end

  // Rises within a frame; saturates, only the header counts matter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rise_q <= 6'h00;
    else if (cs_n)
      rise_q <= 6'h00;
    else if (sck && !sck_q && rise_q != 6'h3F)
      rise_q <= rise_q + 6'h01;
  end

  // Opcode as the device should have seen it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      op_q <= 8'h00;
    else if (!cs_n && sck && !sck_q && rise_q < 6'h08)
      op_q <= {op_q[6:0], si};
  end

  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("sck high outside a frame");
  a_cs_lead_time: assert property ($fell(cs_n) |-> !sck [*8])
    else $error("sck rose too soon after select");
  a_si_moves_low: assert property ($changed(si) |-> !sck)
    else $error("si changed while sck high");
  a_oe_start_pos: assert property ($rose(so_oe) |-> !cs_n && !sck &&
    ((rise_q == 6'h08 && op_q inside {8'h05, 8'h35, 8'h15}) ||
     (rise_q == 6'h18 && op_q == 8'h65) ||
     (rise_q == 6'h28 && op_q == 8'h4B)))
    else $error("output began at wrong clock or opcode");
  a_oe_unknown_op: assert property (!cs_n && rise_q >= 6'h08 &&
    !(op_q inside {8'h05, 8'h35, 8'h15, 8'h65, 8'h4B}) |-> !so_oe)
    else $error("output driven for unknown opcode");
  a_oe_holds_on: assert property (so_oe && !cs_n |=> so_oe)
    else $error("output stopped while selected");
  a_oe_release: assert property (cs_n [*6] |-> !so_oe)
    else $error("output still driven after release");
  a_so_quiet_off: assert property (!so_oe |-> !so)
    else $error("so active while not enabled");
  a_so_steady_hi: assert property (!cs_n && sck && $past(sck) |->
    $stable(so))
    else $error("so changed while sck high");
endmodule

`default_nettype wire

//--- test/tb_top.sv
// Testbench joining host and device ends over the serial link
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [47:0] status_bytes;
  logic [8:0] otp_addr;
  logic [7:0] otp_rdata;
  int errors, num_checks;

  osr_link lnk();
  osr_device i_osr_device(.hclk, .hresetn, .link(lnk.dev), .status_bytes,
    .otp_addr, .otp_rdata, .busy);
  osr_host i_osr_host(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .link(lnk.host));
  osr_link_sva i_osr_link_sva(.hclk, .hresetn, .cs_n(lnk.cs_n),
    .sck(lnk.sck), .si(lnk.si), .so(lnk.so), .so_oe(lnk.so_oe));

  // Security store: distinct bytes either side of a register boundary
  assign otp_rdata = {otp_addr[8:7], otp_addr[5:0]};

  // 200 MHz system clock
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic close_out;
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, got);
    num_checks++;
    if (got !== ex)
    begin
      errors++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask

  // One single word transfer; waits on hready, never assumes a count
  task automatic ahb(input logic w, input logic [31:0] a, wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Status polling, bounded so a stuck flag fails instead of hanging
  task automatic poll(input int b, input logic v);
    logic [31:0] r;
    int t;
    t = 0;
    ahb(1'b0, 32'h8, 32'h0, r);
    while (r[b] !== v && t < 2000)
    begin
      ahb(1'b0, 32'h8, 32'h0, r);
      t++;
    end
    chk("status", {31'h0, v}, {31'h0, r[b]});
  endtask

  // Full frame; chg alters status one after byte 0, byte 1 is a race
  task automatic xfer(input logic [7:0] op, input logic [1:0] ab,
    input logic dm, input logic [23:0] a, input logic [7:0] e[$],
    input logic [7:0] chg);
    logic [31:0] r;
    ahb(1'b1, 32'h4, {8'h00, a}, r);
    ahb(1'b1, 32'h0, {1'b1, 5'h00, 10'(e.size()), 5'h00, dm, ab, op}, r);
    // Well inside the header, so select must be seen by now
    repeat (30) @(posedge hclk);
    chk("busy on", 32'h1, {31'h0, busy});
    foreach (e[i])
    begin
      poll(1, 1'b1);
      ahb(1'b0, 32'hC, 32'h0, r);
      if (!(chg != 8'h00 && i == 1))
        chk("rx byte", {24'h0, e[i]}, r);
      if (chg != 8'h00 && i == 0)
        status_bytes[7:0] <= chg;
    end
    poll(0, 1'b0);
    chk("busy off", 32'h0, {31'h0, busy});
  endtask

  task automatic t_regs;
    logic [31:0] r;
    ahb(1'b0, 32'h0, 32'h0, r);
    chk("ctrl reset", 32'h0, r);
    ahb(1'b1, 32'h4, 32'h00A5C3E1, r);
    ahb(1'b0, 32'h4, 32'h0, r);
    chk("addr", 32'h00A5C3E1, r);
    ahb(1'b1, 32'h10, 32'hFFFFFFFF, r);
    ahb(1'b0, 32'h10, 32'h0, r);
    chk("unmapped", 32'h0, r);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Each direct opcode, two bytes to see the repeat
  task automatic t_direct;
    logic [7:0] ops [3] = '{8'h05, 8'h35, 8'h15};
    foreach (ops[k])
      xfer(ops[k], 2'h0, 1'b0, 24'h0, '{status_bytes[8*k+:8],
        status_bytes[8*k+:8]}, 8'h00);
  endtask

  task automatic t_ind;
    xfer(8'h65, 2'h1, 1'b1, 24'h000001, '{8'h11, 8'h22, 8'h33, 8'h44,
      8'h55, 8'h66, 8'h00}, 8'h00);
  endtask

  task automatic t_wrap;
    xfer(8'h65, 2'h1, 1'b1, 24'h0000FF, '{8'h00, 8'h00, 8'h11},
      8'h00);
  endtask

  // High address bits set; run crosses from register 2 into 3
  task automatic t_otp;
    xfer(8'h4B, 2'h3, 1'b1, 24'hABCD7E, '{8'hBE, 8'hBF, 8'hC0, 8'hC1},
      8'h00);
  endtask

  task automatic t_bad;
    // Two address bytes and a dummy: one address byte short of the longest header the host allows
    xfer(8'h9F, 2'h2, 1'b1, 24'h00F0F0, '{8'h00}, 8'h00);
  endtask

  task automatic t_live;
    xfer(8'h05, 2'h0, 1'b0, 24'h0, '{8'h11, 8'h00, 8'h5A}, 8'h5A);
  endtask

  // Reset, then the scenarios in order
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    status_bytes = 48'h665544332211;
    errors = 0;
    num_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    t_regs;
    t_direct;
    t_ind;
    t_wrap;
    t_otp;
    t_bad;
    t_live;
    close_out;
  end

  // Whole run needs about 9000 cycles; this allows several times that
  initial
  begin
    #300000;
    errors++;
    close_out;
  end
endmodule

`default_nettype wire
